/* File: hw/hsi_pkg.sv */
// Package of register offsets, field positions and reset values for the HDLC status block.
package hsi_pkg;
    // ==========================================
    // Register map. Offsets are word indices; the byte address is four times the index.
    localparam logic [7:0]  FLAGS_IDX      = 8'h01;
    localparam logic [7:0]  ENABLE_IDX     = 8'h02;
    localparam logic [11:0] FLAGS_ADDR     = {2'h0, FLAGS_IDX, 2'h0};
    localparam logic [11:0] ENABLE_ADDR    = {2'h0, ENABLE_IDX, 2'h0};
    // ==========================================
    // Field positions.
    localparam int          CODE_CHG_BIT   = 7;
    localparam int          PKT_END_BIT    = 6;
    localparam int          PKT_START_BIT  = 5;
    localparam int          RX_HALF_BIT    = 4;
    localparam int          RX_DATA_BIT    = 3;
    localparam int          TX_HALF_BIT    = 2;
    localparam int          TX_ROOM_BIT    = 1;
    localparam int          TX_DONE_BIT    = 0;
    localparam logic [7:0]  STICKY_MASK    = 8'he1;
    // ==========================================
    // Reset values.
    localparam logic [7:0]  FLAGS_RESET    = 8'h00;
    localparam logic [7:0]  ENABLE_RESET   = 8'h00;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
    localparam logic        CODE_RESET     = 1'b0;
    // ==========================================
    // FIFO geometry.
    localparam int          FIFO_DEPTH     = 64;
endpackage : hsi_pkg

/* File: hw/hsi_status_irq.sv */
// HDLC status flags, interrupt mask and APB register slave.
// Functional notes
// - Code detector state change sets bit 7.
// - Valid receive message end sets bit 6.
// - CRC error, overrun or abort set bit 6.
// - Packet opening byte sets bit 5.
// - Receive FIFO beyond half sets bit 4.
// - Receive FIFO not empty sets bit 3.
// - Transmit FIFO below half sets bit 2.
// - Transmit FIFO not full sets bit 1.
// - Transmit message finished sets bit 0.
// - Event flags latch, clear on status read.
// - Mask bits align; one enables interrupt.
`timescale 1ns/1ps
module hsi_status_irq
    import hsi_pkg::*;
#(
    parameter int RX_DEPTH = FIFO_DEPTH,
    parameter int TX_DEPTH = FIFO_DEPTH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        code_detected,
    input  wire logic        rx_msg_valid,
    input  wire logic        rx_crc_error,
    input  wire logic        rx_overrun,
    input  wire logic        rx_abort,
    input  wire logic        rx_open_byte,
    input  wire logic [6:0]  rx_fifo_level,
    input  wire logic [6:0]  tx_fifo_level,
    input  wire logic        tx_msg_done,
    output logic             irq
);

    // ==========================================
    // Parameter checks.
    localparam int LVL_W = 7;
    if (RX_DEPTH < 2 || RX_DEPTH >= (1 << LVL_W) || TX_DEPTH < 2 || TX_DEPTH >= (1 << LVL_W))
    begin : g_bad_depth
        $error("FIFO depth out of range");
    end
    localparam logic [LVL_W-1:0] RX_HALF = LVL_W'(RX_DEPTH / 2);
    localparam logic [LVL_W-1:0] TX_HALF = LVL_W'(TX_DEPTH / 2);
    localparam logic [LVL_W-1:0] TX_FULL = LVL_W'(TX_DEPTH);

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
        addr_hit = (a[11:2] == target[11:2]);
    endfunction : addr_hit

    // ==========================================
    // APB decode. Zero wait states, so pready is always high.
    logic access;
    logic wr_en;
    logic rd_flags;
    logic mapped;
    assign access   = psel && penable;
    assign mapped   = addr_hit(paddr, FLAGS_ADDR) || addr_hit(paddr, ENABLE_ADDR);
    assign wr_en    = access && pwrite && addr_hit(paddr, ENABLE_ADDR) && pstrb[0];
    assign rd_flags = access && !pwrite && addr_hit(paddr, FLAGS_ADDR);
    assign pready   = 1'b1;
    assign pslverr  = access && !mapped;

    // ==========================================
    // The code-detect level comes from another block on this clock, so only an edge register.
    logic code_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q <= CODE_RESET;
        end else begin
            code_q <= code_detected;
        end
    end

    // ==========================================
    // Sticky event flags. A new event in the clearing read cycle wins over the clear.
    logic [7:0] event_set;
    logic [7:0] sticky_q;
    logic [7:0] sticky_d;
    always_comb begin
        event_set                = 8'h00;
        event_set[CODE_CHG_BIT]  = code_q ^ code_detected;
        event_set[PKT_END_BIT]   = rx_msg_valid
                                 | rx_crc_error | rx_overrun | rx_abort;
        event_set[PKT_START_BIT] = rx_open_byte;
        event_set[TX_DONE_BIT]   = tx_msg_done;
        sticky_d = (rd_flags ? 8'h00 : sticky_q) | event_set;
        sticky_d = sticky_d & STICKY_MASK;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_q <= FLAGS_RESET;
        end else begin
            sticky_q <= sticky_d;
        end
    end

    // ==========================================
    // Live level flags, not latched, so reads do not disturb them.
    logic [7:0] level_d;
    logic [7:0] level_q;
    always_comb begin
        level_d              = 8'h00;
        level_d[RX_HALF_BIT] = rx_fifo_level > RX_HALF;
        level_d[RX_DATA_BIT] = rx_fifo_level != '0;
        level_d[TX_HALF_BIT] = tx_fifo_level < TX_HALF;
        level_d[TX_ROOM_BIT] = tx_fifo_level < TX_FULL;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= FLAGS_RESET;
        end else begin
            level_q <= level_d;
        end
    end

    // ==========================================
    // Interrupt enable register.
    logic [7:0] enable_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= ENABLE_RESET;
        end else if (wr_en) begin
            enable_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sticky_d & enable_q) | |(level_q & enable_q);
        end
    end

    // ==========================================
    // Read data. Loaded at the setup edge from the next flag value, so an event
    // in the setup cycle is reported before the access edge clears it.
    logic [31:0] rdata_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= RDATA_RESET;
        end else if (psel && !penable) begin
            rdata_q <= RDATA_RESET;
            if (addr_hit(paddr, FLAGS_ADDR)) begin
                rdata_q[7:0] <= sticky_d | level_d;
            end else if (addr_hit(paddr, ENABLE_ADDR)) begin
                rdata_q[7:0] <= enable_q;
            end
        end
    end
    assign prdata = rdata_q;

endmodule : hsi_status_irq

/* File: dv/hsi_status_irq_props.sv */
// Assertions on flag, mask and interrupt timing of the HDLC status block.
`timescale 1ns/1ps
module hsi_status_irq_props
    import hsi_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [3:0]  pstrb,
    input wire logic        code_detected,
    input wire logic        rx_msg_valid,
    input wire logic        rx_crc_error,
    input wire logic        rx_overrun,
    input wire logic        rx_abort,
    input wire logic        rx_open_byte,
    input wire logic        tx_msg_done,
    input wire logic [6:0]  rx_fifo_level,
    input wire logic [6:0]  tx_fifo_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic rd  = acc && !pwrite && paddr == FLAGS_ADDR;
    wire logic ren = acc && !pwrite && paddr == ENABLE_ADDR;
    wire logic wen = acc && pwrite && paddr == ENABLE_ADDR && pstrb[0];
    wire logic ends = rx_msg_valid || rx_crc_error || rx_overrun || rx_abort;
    property p_code; $changed(code_detected) ##[1:2] rd |-> prdata[7]; endproperty
    a_code: assert property (p_code) else $error("code change flag missing");
    property p_end; ends ##[1:2] rd |-> prdata[6]; endproperty
    a_end: assert property (p_end) else $error("packet end flag missing");
    property p_start; rx_open_byte ##[1:2] rd |-> prdata[5]; endproperty
    a_start: assert property (p_start) else $error("packet start flag missing");
    property p_done; tx_msg_done ##[1:2] rd |-> prdata[0]; endproperty
    a_done: assert property (p_done) else $error("message end flag missing");
    property p_lvl; rd |-> prdata[4:1] == {$past(rx_fifo_level) > 7'h20,
        $past(rx_fifo_level) != 7'h00, $past(tx_fifo_level) < 7'h20,
        $past(tx_fifo_level) < 7'h40}; endproperty
    a_lvl: assert property (p_lvl) else $error("level flags wrong");
    property p_clr; rd && !rx_open_byte ##1 !rx_open_byte ##1 !rx_open_byte ##1 rd
        |-> !prdata[5]; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared by read");
    property p_mask; ren && prdata[7:0] == 8'h00 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt raised");
    property p_irq; wen && pwdata[1] && tx_fifo_level < 7'h40 ##1 tx_fifo_level < 7'h40
        |=> irq; endproperty
    a_irq: assert property (p_irq) else $error("enabled interrupt missing");
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
    c_rd: cover property (rd && prdata[0]);
endmodule : hsi_status_irq_props
bind hsi_status_irq hsi_status_irq_props u_props (.*);

/* File: dv/hsi_status_irq_tb_top.sv */
// Self-checking bench for the HDLC status flags, mask and interrupt.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module hsi_status_irq_tb_top
    import hsi_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, code_detected = 0;
    logic irq, pready, pslverr, se;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [6:0]  rxl = '0, txl = '0, tr[5] = '{7'h21, 7'h20, 7'h01, 7'h00, 7'h40};
    logic [6:0]  tt[5] = '{7'h00, 7'h20, 7'h40, 7'h1f, 7'h3f};
    logic [7:0]  te[5] = '{8'h1e, 8'h0a, 8'h08, 8'h06, 8'h1a};
    logic [5:0]  ev = '0;
    logic [7:0]  ex;
    int error_cnt = 0, n_checks = 0;
    always #10 pclk = ~pclk;
    hsi_status_irq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .code_detected, .rx_msg_valid(ev[0]),
        .rx_crc_error(ev[1]), .rx_overrun(ev[2]), .rx_abort(ev[3]), .rx_open_byte(ev[4]),
        .tx_msg_done(ev[5]), .rx_fifo_level(rxl), .tx_fifo_level(txl), .irq);
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // The request is held until pready is seen, for at most 9 edges; data is taken in the access cycle.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        for (k = 0; k < 9; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 9) begin error_cnt++; complete_run(); end
        {se, rd} = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic chk_irq(input logic v);
        repeat (2) @(negedge pclk);
        `CHK(irq, v, "irq level")
        @(posedge pclk);
    endtask : chk_irq
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(0, ENABLE_ADDR, 0); `CHK(rd, 32'h0, "enable reset")
        xfer(0, FLAGS_ADDR, 0); `CHK(rd, 32'h6, "flags reset")
        for (int i = 0; i < 8; i++) begin
            if (i < 6) ev <= 6'h1 << i; else code_detected <= ~code_detected;
            @(posedge pclk) ev <= '0;
            xfer(0, FLAGS_ADDR, 0);
            ex = i < 4 ? 8'h46 : i == 4 ? 8'h26 : i == 5 ? 8'h07 : 8'h86;
            `CHK(rd[7:0], ex, "set")
            xfer(0, FLAGS_ADDR, 0); `CHK(rd, 32'h6, "clear on read")
        end
        $display("event test done");
        for (int i = 0; i < 10; i++) begin
            if (i % 2 == 0) begin rxl <= tr[i/2]; txl <= tt[i/2]; @(posedge pclk); end
            xfer(0, FLAGS_ADDR, 0); `CHK(rd[7:0], te[i/2], "level")
        end
        $display("level test done");
        xfer(1, ENABLE_ADDR, 32'h2); chk_irq(1);
        xfer(0, ENABLE_ADDR, 0); `CHK(rd, 32'h2, "enable readback")
        xfer(1, ENABLE_ADDR, 0); chk_irq(0);
        xfer(1, ENABLE_ADDR, 32'h1); ev <= 6'h20;
        @(posedge pclk) ev <= '0;
        chk_irq(1);
        xfer(0, FLAGS_ADDR, 0); chk_irq(0);
        xfer(0, 12'h00c, 0); `CHK({se, rd}, {1'b1, 32'h0}, "unmapped")
        $display("interrupt test done");
        complete_run();
    end
endmodule : hsi_status_irq_tb_top
